/* hdl/uart_ctl_defines.svh */
// Register offsets, field positions and reset values for the UART control block
`ifndef UART_CTL_DEFINES_SVH
`define UART_CTL_DEFINES_SVH
`define OFS_FIFO_CONTROL   8'h00
`define OFS_LINE_FORMAT    8'h04
`define OFS_MODEM_CONTROL  8'h08
`define OFS_ENHANCED       8'h0c
`define OFS_FEATURE        8'h10
`define OFS_TRIGGER_LEVEL  8'h14
`define OFS_ALT_FUNCTION   8'h18
`define OFS_STATUS         8'h1c
`define FIFO_CTL_EN      0
`define FIFO_CTL_RXRST   1
`define FIFO_CTL_TXRST   2
`define FIFO_CTL_DMA     3
`define FIFO_CTL_TXSEL   5:4
`define FIFO_CTL_RXSEL   7:6
`define ENH_FEAT_ON      4
`define ENH_AUTO_RTS     6
`define FEAT_HALF_DUPLEX 3
`define FEAT_TABLE       5:4
`define FEAT_TRIG_WHICH  7
`define MODEM_DTR        0
`define MODEM_RTS        1
`define MODEM_RING       2
`define MODEM_GOUT2      3
`define MODEM_LOOP       4
`define MODEM_XANY       5
`define MODEM_IR         6
`define MODEM_PRESC      7
`define LINE_PAR_EN      3
`define LINE_EVEN        4
`define LINE_FORCE       5
`define LINE_BREAK       6
`define LINE_DLAB        7
`define RESET_BYTE  8'h00
`define RESP_OKAY   2'b00
`define RESP_SLVERR 2'b10
`define PRESC_LAST  2'h3
`endif

/* hdl/uart_ctl_pkg.sv */
// Types shared by the UART FIFO, line and modem control block
package uart_ctl_pkg;
    typedef enum logic [1:0] {
        TBL_A = 2'b00,
        TBL_B = 2'b01,
        TBL_C = 2'b10,
        TBL_D = 2'b11
    } trig_table_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RESP = 2'b01
    } bus_state_t;
    typedef struct packed {
        logic       fifo_en;
        logic       dma_mode;
        logic [1:0] tx_sel;
        logic [1:0] rx_sel;
        logic       rx_fifo_reset;
        logic       tx_fifo_reset;
    } fifo_cfg_t;
    typedef struct packed {
        logic       dlab;
        logic       brk;
        logic       force_par;
        logic       even_par;
        logic       par_en;
        logic       stop2;
        logic [1:0] wlen;
    } line_cfg_t;
    typedef struct packed {
        logic [5:0] data_bits;
        logic [1:0] stop_halves_m2;
        logic       par_en;
        logic       par_forced;
        logic       par_forced_val;
        logic       par_even;
    } frame_fmt_t;
    typedef struct packed {
        fifo_cfg_t   fifo;
        line_cfg_t   line;
        logic [7:0]  modem;
        logic [7:0]  enh;
        logic [7:0]  feat;
        logic [7:0]  alt;
        logic [7:0]  rx_prog;
        logic [7:0]  tx_prog;
        trig_table_t table_sel;
        bus_state_t  wst;
        bus_state_t  rst;
        logic        aw_hold;
        logic        w_hold;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic [1:0]  bresp;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic [1:0]  presc_cnt;
        logic        presc_tick;
        logic [1:0]  mdm_in_s1;
        logic [1:0]  mdm_in_s2;
    } state_t;
endpackage

/* hdl/uart_fifo_line_modem_control.sv */
// FIFO, line format and modem control registers of one UART channel
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`include "uart_ctl_defines.svh"
//
// Overview of operation
// - Other FIFO control bits are ignored unless the write also sets FIFO enable.
// - Receive or transmit FIFO reset pulses once, shift registers untouched.
// - DMA mode bit selects normal or DMA behaviour of ready pins.
// - Transmit trigger select writable only with enhanced functions enabled.
// - Receive trigger select sets the receive FIFO trigger level.
// - Last written trigger table selection applies to both directions.
// - Tables A, B, C give fixed receive and transmit trigger levels.
// - Table D uses programmable levels; feature bit selects which one is written.
// - Word length bits give five to eight data bits.
// - Stop select gives one, one and a half, or two stop bits.
// - Parity enable adds parity; type bit chooses odd or even.
// - Forced parity fixes the bit at one or zero by type bit.
// - Break bit holds the serial output low until cleared.
// - Divisor access bit steers shared addresses to divisor registers.
// - Modem bit 0 drives terminal-ready pin with inverted sense.
// - Modem bit 1 drives request-to-send low, unless automatic RTS or half-duplex control overrides.
// - Modem bit 2 drives no pin, feeds looped ring indicator.
// - Modem bit 3 drives general output two when alternate field is 00.
// - Modem bit 4 selects internal loopback.
// - Xon-any lets any received character resume halted transmission.
// - Infrared bit routes serial data through the encoder, idle low.
// - Prescaler bit divides the baud generator clock by four.
module uart_fifo_line_modem_control
    import uart_ctl_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        auto_rts_level,
    input  wire logic        half_duplex_level,
    input  wire logic        tx_serial_raw,
    input  wire logic        tx_ir_raw,
    input  wire logic        rx_serial_pin,
    input  wire logic        rx_char_strobe,
    input  wire logic        xon_xoff_match,
    output fifo_cfg_t        fifo_cfg,
    output frame_fmt_t       frame_fmt,
    output logic [7:0]       rx_trigger,
    output logic [7:0]       tx_trigger,
    output logic             divisor_select,
    output logic             tx_serial_pin,
    output logic             rx_serial_core,
    output logic             ir_mode,
    output logic             loopback,
    output logic             loop_ring,
    output logic             loop_carrier,
    output logic             dtr_n_pin,
    output logic             rts_n_pin,
    output logic             general_output_two,
    output logic             xon_any_resume,
    output logic             rx_char_store,
    output logic             baud_clk_en
);

    state_t st;
    state_t next_st;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Fixed table lookup; table D is handled by the caller
    function automatic logic [7:0] rx_level(input trig_table_t t, input logic [1:0] s);
        logic [7:0] v;
        v = 8'h01;
        case (t)
            TBL_A:   v = (s == 2'b00) ? 8'h01 : (s == 2'b01) ? 8'h04 :
                         (s == 2'b10) ? 8'h08 : 8'h0e;
            TBL_B:   v = (s == 2'b00) ? 8'h08 : (s == 2'b01) ? 8'h10 :
                         (s == 2'b10) ? 8'h18 : 8'h1c;
            TBL_C:   v = (s == 2'b00) ? 8'h08 : (s == 2'b01) ? 8'h10 :
                         (s == 2'b10) ? 8'h38 : 8'h3c;
            default: v = 8'h01;
        endcase
        return v;
    endfunction

    function automatic logic [7:0] tx_level(input trig_table_t t, input logic [1:0] s);
        logic [7:0] v;
        v = 8'h01;
        case (t)
            TBL_A:   v = 8'h01;
            TBL_B:   v = (s == 2'b00) ? 8'h10 : (s == 2'b01) ? 8'h08 :
                         (s == 2'b10) ? 8'h18 : 8'h1e;
            TBL_C:   v = (s == 2'b00) ? 8'h08 : (s == 2'b01) ? 8'h10 :
                         (s == 2'b10) ? 8'h20 : 8'h38;
            default: v = 8'h01;
        endcase
        return v;
    endfunction

    // Byte-lane merge of the low byte only; upper lanes hold nothing
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] d,
                                              input logic [3:0] strb);
        return strb[0] ? d[7:0] : old;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic       wr_fire;
    logic [7:0] wb;
    logic       enh_on;

    always_comb begin
        next_st = st;
        wr_fire = 1'b0;
        wb      = `RESET_BYTE;
        enh_on  = st.enh[`ENH_FEAT_ON];
        // FIFO reset bits self-clear the cycle after they are seen
        next_st.fifo.rx_fifo_reset = 1'b0;
        next_st.fifo.tx_fifo_reset = 1'b0;

        // Address and data accepted independently, in either order
        if (st.wst == BUS_IDLE) begin
            if (s_axi_awvalid && !st.aw_hold) begin
                next_st.aw_hold = 1'b1;
                next_st.aw_addr = s_axi_awaddr;
            end
            if (s_axi_wvalid && !st.w_hold) begin
                next_st.w_hold = 1'b1;
                next_st.w_data = s_axi_wdata;
                next_st.w_strb = s_axi_wstrb;
            end
            if (st.aw_hold && st.w_hold) begin
                wr_fire = 1'b1;
            end
        end else if (s_axi_bready) begin
            next_st.wst = BUS_IDLE;
        end

        if (wr_fire) begin
            next_st.wst     = BUS_RESP;
            next_st.aw_hold = 1'b0;
            next_st.w_hold  = 1'b0;
            next_st.bresp   = `RESP_OKAY;
            case (st.aw_addr)
                `OFS_FIFO_CONTROL: begin
                    wb = merge_byte(`RESET_BYTE, st.w_data, st.w_strb);
                    if (st.w_strb[0]) begin
                        next_st.fifo.fifo_en = wb[`FIFO_CTL_EN];
                        // Other bits only land when enable is written as one
                        if (wb[`FIFO_CTL_EN]) begin
                            next_st.fifo.rx_fifo_reset = wb[`FIFO_CTL_RXRST];
                            next_st.fifo.tx_fifo_reset = wb[`FIFO_CTL_TXRST];
                            next_st.fifo.dma_mode      = wb[`FIFO_CTL_DMA];
                            next_st.fifo.rx_sel        = wb[`FIFO_CTL_RXSEL];
                            if (enh_on) begin
                                next_st.fifo.tx_sel = wb[`FIFO_CTL_TXSEL];
                            end
                        end
                    end
                end
                `OFS_LINE_FORMAT: begin
                    next_st.line = merge_byte(st.line, st.w_data, st.w_strb);
                end
                `OFS_MODEM_CONTROL: begin
                    wb = merge_byte(st.modem, st.w_data, st.w_strb);
                    // Upper modem bits need enhanced functions to change
                    next_st.modem[4:0] = wb[4:0];
                    if (enh_on) begin
                        next_st.modem[7:5] = wb[7:5];
                    end
                end
                `OFS_ENHANCED: begin
                    next_st.enh = merge_byte(st.enh, st.w_data, st.w_strb);
                end
                `OFS_FEATURE: begin
                    wb = merge_byte(st.feat, st.w_data, st.w_strb);
                    next_st.feat = wb;
                    // Table select here counts as the latest choice for both sides
                    if (st.w_strb[0]) begin
                        next_st.table_sel = trig_table_t'(wb[`FEAT_TABLE]);
                    end
                end
                `OFS_TRIGGER_LEVEL: begin
                    wb = merge_byte(`RESET_BYTE, st.w_data, st.w_strb);
                    if (st.w_strb[0]) begin
                        if (st.feat[`FEAT_TRIG_WHICH]) begin
                            next_st.tx_prog = wb;
                        end else begin
                            next_st.rx_prog = wb;
                        end
                    end
                end
                `OFS_ALT_FUNCTION: begin
                    next_st.alt = merge_byte(st.alt, st.w_data, st.w_strb);
                end
                `OFS_STATUS: begin
                    next_st.bresp = `RESP_SLVERR;
                end
                default: begin
                    next_st.bresp = `RESP_SLVERR;
                end
            endcase
        end

        // Read channel: one outstanding read
        if (st.rst == BUS_IDLE) begin
            if (s_axi_arvalid) begin
                next_st.rst   = BUS_RESP;
                next_st.rresp = `RESP_OKAY;
                next_st.rdata = '0;
                case (s_axi_araddr)
                    `OFS_FIFO_CONTROL:  next_st.rresp = `RESP_SLVERR;
                    `OFS_LINE_FORMAT:   next_st.rdata[7:0] = st.line;
                    `OFS_MODEM_CONTROL: next_st.rdata[7:0] = st.modem;
                    `OFS_ENHANCED:      next_st.rdata[7:0] = st.enh;
                    `OFS_FEATURE:       next_st.rdata[7:0] = st.feat;
                    `OFS_TRIGGER_LEVEL: next_st.rdata[7:0] =
                        st.feat[`FEAT_TRIG_WHICH] ? st.tx_prog : st.rx_prog;
                    `OFS_ALT_FUNCTION:  next_st.rdata[7:0] = st.alt;
                    `OFS_STATUS:        next_st.rdata[7:0] =
                        {st.fifo.fifo_en, st.fifo.fifo_en, st.table_sel,
                         st.fifo.dma_mode, rts_n_pin, dtr_n_pin, tx_serial_pin};
                    default:            next_st.rresp = `RESP_SLVERR;
                endcase
            end
        end else if (s_axi_rready) begin
            next_st.rst = BUS_IDLE;
        end

        // The table is chosen only through the feature register, so a FIFO
        // control write never moves it; both directions read the one table.
        // Keeping a single table register stops the two sides drifting apart
        // when software reprograms the level of only one direction.

        // Prescaler: enable every cycle, or every fourth when divide-by-four
        next_st.presc_cnt  = st.presc_cnt + 2'h1;
        next_st.presc_tick = (st.modem[`MODEM_PRESC] && enh_on) ?
                             (st.presc_cnt == `PRESC_LAST) : 1'b1;

        // Synchronise the external serial input; the low bit is tied to zero
        next_st.mdm_in_s1 = {rx_serial_pin, 1'b0};
        next_st.mdm_in_s2 = st.mdm_in_s1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus outputs: ready when idle and the channel slot is free

    assign s_axi_awready = (st.wst == BUS_IDLE) && !st.aw_hold;
    assign s_axi_wready  = (st.wst == BUS_IDLE) && !st.w_hold;
    assign s_axi_bvalid  = (st.wst == BUS_RESP);
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = (st.rst == BUS_IDLE);
    assign s_axi_rvalid  = (st.rst == BUS_RESP);
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration outputs

    logic en_ir;
    logic en_xany;
    assign en_ir   = st.enh[`ENH_FEAT_ON] && st.modem[`MODEM_IR];
    assign en_xany = st.enh[`ENH_FEAT_ON] && st.modem[`MODEM_XANY];

    assign fifo_cfg       = st.fifo;
    assign divisor_select = st.line.dlab;

    // Table D takes both levels from the programmable registers
    assign rx_trigger = (st.table_sel == TBL_D) ? st.rx_prog :
                        rx_level(st.table_sel, st.fifo.rx_sel);
    assign tx_trigger = (st.table_sel == TBL_D) ? st.tx_prog :
                        tx_level(st.table_sel, st.fifo.tx_sel);

    // Frame format decoded once for both serial engines
    always_comb begin
        frame_fmt.data_bits      = 6'd5 + {4'h0, st.line.wlen};
        frame_fmt.stop_halves_m2 = !st.line.stop2 ? 2'd0 :
                                   (st.line.wlen == 2'b00) ? 2'd1 : 2'd2;
        frame_fmt.par_en         = st.line.par_en;
        frame_fmt.par_even       = st.line.even_par;
        frame_fmt.par_forced     = st.line.par_en && st.line.force_par;
        frame_fmt.par_forced_val = !st.line.even_par;
    end

    // Break dominates; infrared idles low, loopback keeps the pin at mark, or low when infrared is on
    assign ir_mode        = en_ir;
    assign loopback       = st.modem[`MODEM_LOOP];
    assign tx_serial_pin  = st.line.brk ? 1'b0 :
                            st.modem[`MODEM_LOOP] ? (en_ir ? 1'b0 : 1'b1) :
                            (en_ir ? tx_ir_raw : tx_serial_raw);
    assign rx_serial_core = st.modem[`MODEM_LOOP] ? (en_ir ? tx_ir_raw : tx_serial_raw)
                                                  : st.mdm_in_s2[1];
    assign loop_ring      = st.modem[`MODEM_RING];
    assign loop_carrier   = st.modem[`MODEM_GOUT2];

    // Modem pins are inactive high; loopback parks them inactive
    assign dtr_n_pin = st.modem[`MODEM_LOOP] ? 1'b1 : !st.modem[`MODEM_DTR];
    assign rts_n_pin = st.modem[`MODEM_LOOP] ? 1'b1 :
                       (st.enh[`ENH_AUTO_RTS] ? auto_rts_level :
                        st.feat[`FEAT_HALF_DUPLEX] ? half_duplex_level :
                        !st.modem[`MODEM_RTS]);
    assign general_output_two = (st.alt[2:1] == 2'b00 && !st.modem[`MODEM_LOOP]) ?
                                !st.modem[`MODEM_GOUT2] : 1'b1;

    // Xon-any: resume on any char, store unless it is a flow-control char
    assign xon_any_resume = en_xany && rx_char_strobe;
    assign rx_char_store  = rx_char_strobe && !(xon_xoff_match && st.enh[3:0] != 4'h0);
    assign baud_clk_en    = st.presc_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    logic [0:0] en_presc_hold;
    assign en_presc_hold[0] = st.modem[`MODEM_PRESC] && st.enh[`ENH_FEAT_ON];

    AST_FIFO_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
        !st.fifo.fifo_en |=> !st.fifo.rx_fifo_reset && !st.fifo.tx_fifo_reset ||
        $rose(st.fifo.fifo_en))
        else $error("fifo reset set without enable");
    AST_RST_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
        st.fifo.rx_fifo_reset |=> !st.fifo.rx_fifo_reset)
        else $error("rx fifo reset did not self clear");
    AST_BREAK: assert property (@(posedge aclk) disable iff (!aresetn)
        st.line.brk |-> !tx_serial_pin)
        else $error("break not holding line low");
    AST_DTR: assert property (@(posedge aclk) disable iff (!aresetn)
        !loopback |-> dtr_n_pin == !st.modem[`MODEM_DTR])
        else $error("dtr pin sense wrong");
    AST_PRESC: assert property (@(posedge aclk) disable iff (!aresetn)
        // The first tick after switching the divider on may still be an undivided one
        (en_presc_hold[0] && $past(en_presc_hold[0]) && baud_clk_en) |=>
        (!baud_clk_en || !en_presc_hold[0]) [*3])
        else $error("prescaler tick too close");
    AST_TBL_A_TX: assert property (@(posedge aclk) disable iff (!aresetn)
        st.table_sel == TBL_A |-> tx_trigger == 8'h01)
        else $error("table A transmit level wrong");
    AST_STOP: assert property (@(posedge aclk) disable iff (!aresetn)
        !st.line.stop2 |-> frame_fmt.stop_halves_m2 == 2'd0)
        else $error("stop bits wrong");
    AST_FORCE: assert property (@(posedge aclk) disable iff (!aresetn)
        frame_fmt.par_forced |-> frame_fmt.par_forced_val != st.line.even_par)
        else $error("forced parity value wrong");
    AST_BVALID: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");

    COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
    COV_READ:  cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);
    COV_TBL_D: cover property (@(posedge aclk) disable iff (!aresetn) st.table_sel == TBL_D);
    COV_LOOP:  cover property (@(posedge aclk) disable iff (!aresetn) loopback && st.line.brk);

endmodule

/* verif/remote_serial_dev.sv */
// Remote serial device model driving the receive side of the channel
module remote_serial_dev (
    input  wire logic clk,
    input  wire logic rstn,
    output logic      line = 1'b1,
    output logic      strobe = 1'b0,
    output logic      match = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 45039;
    int cnt = 0;
    ////////////////////////////////////////////////////////////////////////////
    // One character every 41 cycles; line idles at mark like a pulled-up wire
    always @(posedge clk) begin
        cnt <= (cnt == 40) ? 0 : cnt + 1;
        line <= (!rstn || cnt >= 10) ? 1'b1 : 1'($random(seed));
        strobe <= rstn && cnt == 12; // Received-character event
        match <= (cnt == 12) ? 1'($random(seed)) : 1'b0;
    end
endmodule

/* verif/tb_uart_fifo_line_modem_control.sv */
// Self-checking bench for the UART FIFO, line and modem control block
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_uart_fifo_line_modem_control;
    import uart_ctl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, tx_serial_raw = 0, tx_ir_raw = 0;
    logic auto_rts_level = 0, half_duplex_level = 0, rx_serial_pin, rx_char_strobe;
    logic xon_xoff_match, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, divisor_select, tx_serial_pin, rx_serial_core, ir_mode, loopback;
    logic loop_ring, loop_carrier, dtr_n_pin, rts_n_pin, general_output_two;
    logic xon_any_resume, rx_char_store, baud_clk_en;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rx_trigger, tx_trigger, d;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    fifo_cfg_t   fifo_cfg;
    frame_fmt_t  frame_fmt;
    int seed = 45039, errors = 0, tests_run = 0, pulses = 0, cyc = 0, n = 0;
    localparam logic [7:0] rxl [12] = '{8'h01, 8'h04, 8'h08, 8'h0e, 8'h08, 8'h10,
        8'h18, 8'h1c, 8'h08, 8'h10, 8'h38, 8'h3c};
    localparam logic [7:0] txl [12] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h10, 8'h08,
        8'h18, 8'h1e, 8'h08, 8'h10, 8'h20, 8'h38};
    uart_fifo_line_modem_control DUT (.*);
    remote_serial_dev far_end (.clk(aclk), .rstn(aresetn), .line(rx_serial_pin),
        .strobe(rx_char_strobe), .match(xon_xoff_match));
    always #10 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////
    // Random flow-control levels, reset-pulse count and hang guard
    always @(posedge aclk) begin
        {auto_rts_level, half_duplex_level, tx_ir_raw} <= 3'($random(seed));
        pulses <= pulses + (fifo_cfg.rx_fifo_reset === 1'b1) + (fifo_cfg.tx_fifo_reset === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Bus write: address and data offered together, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= 4'h1;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 0;
        @(posedge aclk); // Gap so the next request never lands on the same step
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
        @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        `CHK(dtr_n_pin, 1'b1)
        `CHK(rts_n_pin, 1'b1)
        `CHK(general_output_two, 1'b1)
        `CHK(fifo_cfg.fifo_en, 1'b0)
        `CHK(rx_trigger, 8'h01)
        $display("reset test done");
        repeat (16) begin
            d = $random(seed);
            tx_serial_raw <= $random(seed);
            wr(8'h04, d);
            rd(8'h04);
            `CHK(rdat, {24'h0, d})
            `CHK(frame_fmt.data_bits, 6'd5 + d[1:0])
            `CHK(frame_fmt.stop_halves_m2, d[2] ? (d[1:0] == 0 ? 2'd1 : 2'd2) : 2'd0)
            `CHK({frame_fmt.par_en, frame_fmt.par_even}, {d[3], d[4]})
            `CHK({frame_fmt.par_forced, frame_fmt.par_forced_val}, {d[3] & d[5], ~d[4]})
            `CHK(tx_serial_pin, d[6] ? 1'b0 : tx_serial_raw)
            `CHK(divisor_select, d[7])
        end
        wr(8'h04, 8'h00);
        $display("line format test done");
        // Fixed tables: the table select lives apart from the level selects
        wr(8'h0c, 8'h10);
        for (int t = 0; t < 3; t++) for (int s = 0; s < 4; s++) begin
            wr(8'h10, 8'(t << 4));
            wr(8'h00, {s[1:0], s[1:0], 4'h1});
            `CHK(rx_trigger, rxl[t * 4 + s])
            `CHK(tx_trigger, txl[t * 4 + s])
        end
        d = $random(seed);
        wr(8'h10, 8'h30);
        wr(8'h14, d);
        wr(8'h10, 8'hb0);
        wr(8'h14, ~d);
        `CHK(rx_trigger, d)
        `CHK(tx_trigger, ~d)
        $display("trigger test done");
        wr(8'h00, 8'h49);
        `CHK(fifo_cfg.dma_mode, 1'b1)
        wr(8'h00, 8'h88);
        `CHK({fifo_cfg.fifo_en, fifo_cfg.rx_sel, fifo_cfg.dma_mode}, 4'b0011)
        wr(8'h00, 8'h06);
        wr(8'h00, 8'h07);
        `CHK(pulses, 2)
        $display("fifo control test done");
        repeat (16) begin
            d = $random(seed);
            wr(8'h08, d);
            rd(8'h08);
            `CHK(rdat[7:0], d)
            `CHK({loopback, ir_mode}, {d[4], d[6]})
            if (d[4]) begin
                `CHK({loop_ring, loop_carrier}, {d[2], d[3]})
                `CHK(rx_serial_core, d[6] ? tx_ir_raw : tx_serial_raw)
            end else begin
                `CHK({dtr_n_pin, rts_n_pin, general_output_two}, ~{d[0], d[1], d[3]})
            end
            // Wait for a character from the far end; no flow-control chars are set up
            do @(posedge aclk); while (!rx_char_strobe);
            `CHK({xon_any_resume, rx_char_store}, {d[5], 1'b1})
            n = 0;
            repeat (8) begin
                @(posedge aclk);
                n += baud_clk_en;
            end
            `CHK(n, d[7] ? 2 : 8)
        end
        wr(8'h08, 8'h00);
        wr(8'h0c, 8'h50);
        `CHK(rts_n_pin, auto_rts_level)
        wr(8'h0c, 8'h00);
        wr(8'h10, 8'h08);
        `CHK(rts_n_pin, half_duplex_level)
        wr(8'h00, 8'h31);
        `CHK(fifo_cfg.tx_sel, 2'b00)
        wr(8'h08, 8'he0);
        `CHK(ir_mode, 1'b0)
        rd(8'h00);
        `CHK(resp, 2'b10)
        wr(8'h1c, 8'h55);
        `CHK(resp, 2'b10)
        $display("modem and access test done");
        finish_test();
    end
endmodule
